// ==== core/epb_pkg.sv ====
// ****************************************************************
// shared constants and types of the protect boundary block
// ****************************************************************
package epb_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  // worst programming time, plain default since no figure is given
  localparam int unsigned PROG_TIME_NS = 10000000;
  localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // instruction frame layout
  // ****************************************************************
  localparam int unsigned OP_W = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned WADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORD_W = OP_W + ADDR_W + DATA_W;
  localparam int unsigned CNT_W = 5;
  // bits after the start bit: short frames and memory write frames
  localparam logic [CNT_W-1:0] SHORT_BITS = 5'h0A;
  localparam logic [CNT_W-1:0] WRITE_BITS = 5'h1A;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
  localparam int unsigned WORD_OP_LSB = ADDR_W + DATA_W;
  localparam int unsigned WORD_ADDR_LSB = DATA_W;

  // ****************************************************************
  // opcodes and address sub-codes
  // ****************************************************************
  localparam logic [OP_W-1:0] OP_EXT = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_READ = 2'h2;
  localparam logic [OP_W-1:0] OP_CLEAR = 2'h3;
  localparam logic [1:0] SUB_PERMIT = 2'h3;
  localparam logic [1:0] SUB_FORBID = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_ALL_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ALL_ONE = 8'hFF;

  // ****************************************************************
  // boundary register
  // ****************************************************************
  localparam logic [ADDR_W-1:0] BOUNDARY_RST = 8'hFF;
  localparam logic [ADDR_W-1:0] BOUNDARY_CLEARED = 8'hFF;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic permit_ok;
    logic sel_hi;
    logic sel_lo;
  } epb_cmd_s;

  typedef enum logic [2:0] {
    CM_NONE = 3'h0,
    CM_MEM = 3'h1,
    CM_BWRITE = 3'h2,
    CM_CLEAR = 3'h3,
    CM_LOCK = 3'h4
  } epb_commit_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_READY = 2'h3
  } epb_state_e;

endpackage : epb_pkg

// ==== core/epb_prog_timer.sv ====
`timescale 1ns/10ps
// ****************************************************************
// self-timed programming counter
// ****************************************************************
module epb_prog_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // a start while busy is dropped; the caller never issues one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        busy_o <= 1'b1;
        count <= '0;
      end else if (busy_o) begin
        if (count == LAST) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule : epb_prog_timer

// ==== core/epb_protect.sv ====
`timescale 1ns/10ps
module epb_protect #(
  parameter int unsigned PROG_CYCLES = epb_pkg::PROG_CYCLES
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // serial link pins
  input wire logic shift_clock_line_i,
  input wire logic chip_select_i,
  input wire logic serial_in_line_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // enable pins
  input wire logic program_permit_pin_i,
  input wire logic protect_select_i,
  // memory programming request
  output logic mem_prog_start_o,
  output logic [epb_pkg::WADDR_W-1:0] mem_prog_addr_o,
  output logic [epb_pkg::DATA_W-1:0] mem_prog_data_o,
  // state view
  output logic [epb_pkg::ADDR_W-1:0] boundary_o,
  output logic locked_o,
  output logic write_enabled_o,
  output logic busy_o
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // top address stays writable when the boundary holds all ones
  function automatic logic is_protected(input logic [epb_pkg::ADDR_W-1:0] bnd,
                                        input logic [epb_pkg::ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (bnd != epb_pkg::BOUNDARY_CLEARED) begin
      hit = addr[epb_pkg::WADDR_W-1:0] >= bnd[epb_pkg::WADDR_W-1:0];
    end
    return hit;
  endfunction : is_protected

  function automatic logic sub_is(input logic [epb_pkg::ADDR_W-1:0] addr,
                                  input logic [1:0] code);
    return addr[epb_pkg::ADDR_W-1 -: 2] == code;
  endfunction : sub_is

  // ****************************************************************
  // link domain: frame shifter on the shift clock
  // ****************************************************************
  logic frame_rst_n;
  logic started;
  logic [epb_pkg::CNT_W-1:0] cnt;
  logic [epb_pkg::WORD_W-2:0] shreg;
  logic [epb_pkg::OP_W-1:0] op;
  logic permit_low;
  logic sel_low;
  logic sel_high;
  logic [epb_pkg::WORD_W-1:0] word;
  logic [epb_pkg::CNT_W-1:0] frame_len;
  logic last_bit;
  epb_pkg::epb_cmd_s hold;
  logic hold_tog;
  logic start_tog;

  assign frame_rst_n = nrst_i & chip_select_i;
  assign word = {shreg, serial_in_line_i};
  assign frame_len = (op == epb_pkg::OP_WRITE && !sel_high && !protect_select_i) ?
                     epb_pkg::WRITE_BITS : epb_pkg::SHORT_BITS;
  assign last_bit = started && (cnt == frame_len - 1'b1);

  // leading zeros before the start bit are ignored
  always_ff @(posedge shift_clock_line_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      started <= 1'b0;
      cnt <= '0;
      shreg <= '0;
      op <= '0;
      permit_low <= 1'b0;
      sel_low <= 1'b0;
      sel_high <= 1'b0;
    end else if (!started) begin
      started <= serial_in_line_i;
    end else if (cnt != epb_pkg::CNT_MAX) begin
      shreg <= word[epb_pkg::WORD_W-2:0];
      cnt <= cnt + 1'b1;
      if (cnt == 5'h01) begin
        op <= {shreg[0], serial_in_line_i};
      end
      permit_low <= permit_low | ~program_permit_pin_i;
      sel_low <= sel_low | ~protect_select_i;
      sel_high <= sel_high | protect_select_i;
    end
  end

  // frame result survives chip select low; toggles carry events across
  always_ff @(posedge shift_clock_line_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold <= '0;
      hold_tog <= 1'b0;
      start_tog <= 1'b0;
    end else begin
      if (chip_select_i && !started && serial_in_line_i) begin
        start_tog <= ~start_tog;
      end
      if (chip_select_i && last_bit) begin
        hold.op <= op;
        hold.addr <= (frame_len == epb_pkg::WRITE_BITS) ?
                     word[epb_pkg::WORD_ADDR_LSB +: epb_pkg::ADDR_W] :
                     word[epb_pkg::ADDR_W-1:0];
        hold.data <= word[epb_pkg::DATA_W-1:0];
        hold.permit_ok <= ~permit_low & program_permit_pin_i;
        hold.sel_hi <= ~sel_low & protect_select_i;
        hold.sel_lo <= ~sel_high & ~protect_select_i;
        hold_tog <= ~hold_tog;
      end
    end
  end

  // ****************************************************************
  // crossing into the system clock
  // ****************************************************************
  logic [4:0] sync_out;
  logic cs_s;
  logic permit_s;
  logic sel_s;
  logic hold_tog_s;
  logic start_tog_s;
  logic cs_q;
  logic hold_tog_q;
  logic start_tog_q;

  epb_sync2 #(
    .W(5)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({chip_select_i, program_permit_pin_i, protect_select_i, hold_tog, start_tog}),
    .sync_o(sync_out)
  );

  assign {cs_s, permit_s, sel_s, hold_tog_s, start_tog_s} = sync_out;

  // edge memories read only synchronised levels
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_q <= 1'b0;
      hold_tog_q <= 1'b0;
      start_tog_q <= 1'b0;
    end else begin
      cs_q <= cs_s;
      hold_tog_q <= hold_tog_s;
      start_tog_q <= start_tog_s;
    end
  end

  // ****************************************************************
  // instruction decode at chip select fall
  // ****************************************************************
  logic new_cmd;
  logic cs_fall;
  logic start_seen;
  logic pending;
  epb_pkg::epb_cmd_s cmd_q;
  epb_pkg::epb_cmd_s cmd;
  logic exec;
  logic accept;
  logic prot_pins;
  logic mem_pins;
  logic d_permit;
  logic d_forbid;
  logic d_write;
  logic d_arm;
  logic d_clear;
  logic d_bwrite;
  logic d_lock;
  logic arm_ok;
  logic clear_ok;
  logic bw_ok;
  logic lock_ok;
  logic mw_ok;
  logic start_prog;

  assign new_cmd = hold_tog_s ^ hold_tog_q;
  assign cs_fall = cs_q & ~cs_s;
  assign start_seen = start_tog_s ^ start_tog_q;
  // hold is stable once its toggle has passed the synchroniser
  assign cmd = new_cmd ? hold : cmd_q;
  assign exec = cs_fall & (pending | new_cmd);

  assign prot_pins = cmd.permit_ok & cmd.sel_hi & permit_s & sel_s;
  assign mem_pins = cmd.permit_ok & cmd.sel_lo & permit_s & ~sel_s;

  assign d_permit = cmd.sel_lo && cmd.op == epb_pkg::OP_EXT &&
                    sub_is(cmd.addr, epb_pkg::SUB_PERMIT);
  assign d_forbid = cmd.sel_lo && cmd.op == epb_pkg::OP_EXT &&
                    sub_is(cmd.addr, epb_pkg::SUB_FORBID);
  assign d_write = cmd.sel_lo && cmd.op == epb_pkg::OP_WRITE;
  assign d_arm = cmd.sel_hi && cmd.op == epb_pkg::OP_EXT &&
                 sub_is(cmd.addr, epb_pkg::SUB_PERMIT);
  assign d_clear = cmd.sel_hi && cmd.op == epb_pkg::OP_CLEAR &&
                   cmd.addr == epb_pkg::ADDR_ALL_ONE;
  assign d_bwrite = cmd.sel_hi && cmd.op == epb_pkg::OP_WRITE;
  assign d_lock = cmd.sel_hi && cmd.op == epb_pkg::OP_EXT &&
                  cmd.addr == epb_pkg::ADDR_ALL_ZERO;

  logic [epb_pkg::ADDR_W-1:0] boundary;
  logic locked;
  logic cleared;
  logic armed;
  logic wen;
  epb_pkg::epb_state_e state;
  epb_pkg::epb_state_e next_state;

  assign arm_ok = d_arm & wen & prot_pins & ~locked;
  assign clear_ok = d_clear & armed & prot_pins & ~locked;
  assign bw_ok = d_bwrite & armed & cleared & prot_pins & ~locked;
  assign lock_ok = d_lock & armed & prot_pins & ~locked;
  assign mw_ok = d_write & wen & mem_pins & ~is_protected(boundary, cmd.addr);
  assign accept = exec & (state != epb_pkg::ST_BUSY);
  assign start_prog = accept & (clear_ok | bw_ok | lock_ok | mw_ok);

  // pending frame waits for the select fall; set wins over clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending <= 1'b0;
      cmd_q <= '0;
    end else begin
      pending <= new_cmd | (pending & ~cs_fall);
      if (new_cmd) begin
        cmd_q <= hold;
      end
    end
  end

  // ****************************************************************
  // programming cycle and status
  // ****************************************************************
  logic prog_busy;
  logic prog_done;
  epb_pkg::epb_commit_e commit;
  logic [epb_pkg::ADDR_W-1:0] commit_addr;

  epb_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(start_prog),
    .busy_o(prog_busy),
    .done_o(prog_done)
  );

  // state walk: idle, busy, ready shown, back to idle on a start bit
  always_comb begin
    next_state = state;
    case (state)
      epb_pkg::ST_IDLE: begin
        if (start_prog) begin
          next_state = epb_pkg::ST_BUSY;
        end
      end
      epb_pkg::ST_BUSY: begin
        if (prog_done) begin
          next_state = epb_pkg::ST_READY;
        end
      end
      epb_pkg::ST_READY: begin
        if (start_prog) begin
          next_state = epb_pkg::ST_BUSY;
        end else if (start_seen) begin
          next_state = epb_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = epb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= epb_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // mode flags; any executed frame ends the armed window
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed <= 1'b0;
      wen <= 1'b0;
    end else begin
      if (exec) begin
        armed <= accept & arm_ok;
      end
      if (accept && d_permit) begin
        wen <= 1'b1;
      end else if (accept && d_forbid) begin
        wen <= 1'b0;
      end
    end
  end

  // commit chosen at start, applied at completion
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      commit <= epb_pkg::CM_NONE;
      commit_addr <= '0;
    end else if (start_prog) begin
      commit_addr <= cmd.addr;
      if (mw_ok) begin
        commit <= epb_pkg::CM_MEM;
      end else if (bw_ok) begin
        commit <= epb_pkg::CM_BWRITE;
      end else if (clear_ok) begin
        commit <= epb_pkg::CM_CLEAR;
      end else begin
        commit <= epb_pkg::CM_LOCK;
      end
    end
  end

  // boundary register; the write clears the cleared mark again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boundary <= epb_pkg::BOUNDARY_RST;
      cleared <= 1'b0;
      locked <= 1'b0;
    end else if (prog_done) begin
      if (commit == epb_pkg::CM_BWRITE) begin
        boundary <= {1'b0, commit_addr[epb_pkg::WADDR_W-1:0]};
        cleared <= 1'b0;
      end else if (commit == epb_pkg::CM_CLEAR) begin
        boundary <= epb_pkg::BOUNDARY_CLEARED;
        cleared <= 1'b1;
      end else if (commit == epb_pkg::CM_LOCK) begin
        locked <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // memory request pulses as the cycle begins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_prog_start_o <= 1'b0;
      mem_prog_addr_o <= '0;
      mem_prog_data_o <= '0;
    end else begin
      mem_prog_start_o <= start_prog & mw_ok;
      if (start_prog && mw_ok) begin
        mem_prog_addr_o <= cmd.addr[epb_pkg::WADDR_W-1:0];
        mem_prog_data_o <= cmd.data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_out_o <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_o <= (next_state == epb_pkg::ST_READY);
      serial_out_oe_o <= cs_s & (next_state != epb_pkg::ST_IDLE);
    end
  end

  assign boundary_o = boundary;
  assign locked_o = locked;
  assign write_enabled_o = wen;
  assign busy_o = prog_busy;

endmodule : epb_protect

// ==== core/epb_sync2.sv ====
`timescale 1ns/10ps
// ****************************************************************
// two flip-flop level synchroniser
// ****************************************************************
module epb_sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : epb_sync2

// ==== testbench/epb_host_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// host driving the serial link
// ****************************************************************
module epb_host_model (
  // link pins
  output logic sclk_o,
  output logic cs_o,
  output logic sdata_o,
  // enable pins
  output logic permit_o,
  output logic sel_o
);
  // idle levels; shift clock stands still between frames
  initial begin
    sclk_o = 1'b0;
    cs_o = 1'b0;
    sdata_o = 1'b0;
    permit_o = 1'b1;
    sel_o = 1'b0;
  end
  // one bit per 48 ns shift period
  task automatic put(input logic b);
    sdata_o = b;
    #24 sclk_o = 1'b1;
    #24 sclk_o = 1'b0;
  endtask : put
  // pins held, select dropped before next edge
  task automatic frame(input logic sel, input logic permit, input logic [1:0] op,
      input logic [7:0] a, input logic [15:0] d);
    #7 sel_o = sel;
    permit_o = permit;
    cs_o = 1'b1;
    put(1'b1);
    for (int i = 1; i >= 0; i--) put(op[i]);
    for (int i = 7; i >= 0; i--) put(a[i]);
    if (op == epb_pkg::OP_WRITE && !sel) begin
      for (int i = 15; i >= 0; i--) put(d[i]);
    end
    #10 cs_o = 1'b0;
    sdata_o = ~sdata_o;
    #300;
  endtask : frame
endmodule : epb_host_model

// ==== testbench/epb_protect_monitor.sv ====
`timescale 1ns/10ps
// ****************************************************************
// port checker of the protect boundary block
// ****************************************************************
module epb_protect_monitor #(
  parameter int unsigned PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // watched pins and state
  input wire logic chip_select_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic mem_prog_start_o,
  input wire logic [epb_pkg::WADDR_W-1:0] mem_prog_addr_o,
  input wire logic [epb_pkg::ADDR_W-1:0] boundary_o,
  input wire logic locked_o,
  input wire logic busy_o
);
  int unsigned busy_len;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // length of the busy run, held one cycle past its end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_o ? busy_len + 1 : 0;
    end
  end
  a_busy_length: assert property ($fell(busy_o) |-> busy_len == PROG_CYCLES)
    else $error("busy run length wrong");
  a_busy_after_fall: assert property ($rose(busy_o) |-> !chip_select_i)
    else $error("busy began with select high");
  a_busy_shows_low: assert property (busy_o && serial_out_oe_o |-> !serial_out_o)
    else $error("busy not shown low");
  a_ready_high: assert property (serial_out_oe_o && !busy_o && !$past(busy_o)
    |-> serial_out_o)
    else $error("ready not shown high");
  a_released_cs_low: assert property (!chip_select_i [*4] |=> !serial_out_oe_o)
    else $error("output driven with select low");
  // lock timing and permanence
  // registers update one cycle after busy falls, at the edge that samples the done pulse raised with it
  a_lock_at_done: assert property ($rose(locked_o) |-> !busy_o && $past(busy_o, 2))
    else $error("lock outside cycle end");
  a_lock_sticks: assert property (locked_o |=> locked_o && $stable(boundary_o))
    else $error("locked state or boundary changed");
  // boundary only moves at a cycle end
  a_bound_at_done: assert property (!$stable(boundary_o) |-> !busy_o && $past(busy_o, 2))
    else $error("boundary changed outside cycle end");
  a_mem_below: assert property (mem_prog_start_o && boundary_o != 8'hFF
    |-> mem_prog_addr_o < boundary_o[6:0])
    else $error("protected word programmed");
  a_bound_msb: assert property (boundary_o != 8'hFF |-> !boundary_o[7])
    else $error("boundary msb set");
  c_busy: cover property ($rose(busy_o));
  c_lock: cover property ($rose(locked_o));
  c_mem: cover property (mem_prog_start_o);
endmodule : epb_protect_monitor

bind epb_protect epb_protect_monitor #(
  .PROG_CYCLES(PROG_CYCLES)
) i_monitor (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .chip_select_i(chip_select_i),
  .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o),
  .mem_prog_start_o(mem_prog_start_o),
  .mem_prog_addr_o(mem_prog_addr_o),
  .boundary_o(boundary_o),
  .locked_o(locked_o),
  .busy_o(busy_o)
);

// ==== testbench/epb_protect_tb_top.sv ====
`timescale 1ns/10ps
// ****************************************************************
// bench of the protect boundary block
// ****************************************************************
module epb_protect_tb_top;
  localparam int unsigned PC = 20;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sclk, cs, sdata, permit, sel, dout, doe, mst, wen, busy, lck;
  logic [6:0] ma, last_a;
  logic [15:0] md, last_d;
  logic [7:0] bnd;
  int num_errors = 0;
  int checks_done = 0;
  int starts = 0;
  always #25 clk_i = ~clk_i;
  epb_host_model i_host (.sclk_o(sclk), .cs_o(cs), .sdata_o(sdata), .permit_o(permit),
    .sel_o(sel));
  epb_protect #(.PROG_CYCLES(PC)) i_dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .shift_clock_line_i(sclk),
    .chip_select_i(cs),
    .serial_in_line_i(sdata),
    .serial_out_o(dout),
    .serial_out_oe_o(doe),
    .program_permit_pin_i(permit),
    .protect_select_i(sel),
    .mem_prog_start_o(mst),
    .mem_prog_addr_o(ma),
    .mem_prog_data_o(md),
    .boundary_o(bnd),
    .locked_o(lck),
    .write_enabled_o(wen),
    .busy_o(busy)
  );
  // mid-cycle sampling keeps clear of the launching edge
  always @(negedge clk_i) begin
    if (mst === 1'b1) begin
      starts++;
      last_a = ma;
      last_d = md;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmd(input logic s, input logic [1:0] op, input logic [7:0] a);
    i_host.frame(s, 1'b1, op, a, 16'hA5C3);
  endtask : cmd
  // protect-arm goes right before each protect instruction except the refused boundary write that follows the write-enable frame
  task automatic arm;
    cmd(1'b1, epb_pkg::OP_EXT, 8'hC7);
  endtask : arm
  // memory word write, then idle past the programming time
  task automatic mw(input logic [7:0] a);
    cmd(1'b0, epb_pkg::OP_WRITE, a);
    repeat (PC + 10) @(posedge clk_i);
  endtask : mw
  task automatic cs_cycle;
    i_host.cs_o = 1'b0;
    repeat (5) @(posedge clk_i);
    #2 i_host.cs_o = 1'b1;
    repeat (5) @(posedge clk_i);
    #2;
  endtask : cs_cycle
  // with exp high, checks busy and polls status until ready before the next instruction; with exp low, checks that no cycle started
  task automatic wait_ready(input logic exp);
    int n;
    n = 0;
    @(posedge clk_i);
    #2 i_host.cs_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #2;
    check({doe, busy, dout & doe}, exp ? 8'h06 : 8'h00);
    if (exp) begin
      cs_cycle;
      while (dout !== 1'b1 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      repeat (4) @(posedge clk_i);
      #2;
      check({doe, busy, dout}, 8'h05);
      cs_cycle;
      check(doe, 1'b1);
      i_host.put(1'b1);
      repeat (5) @(posedge clk_i);
      #2;
      check(doe, 1'b0);
    end
    #2 i_host.cs_o = 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : wait_ready
  task automatic t_enables;
    logic [7:0] a [3] = '{8'hD5, 8'h2A, 8'hC0};
    check(bnd, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      cmd(1'b0, epb_pkg::OP_EXT, a[i]);
      check(wen, a[i][7]);
    end
    $display("enable test done");
  endtask : t_enables
  task automatic t_refused;
    arm;
    cmd(1'b1, epb_pkg::OP_WRITE, 8'h10);
    wait_ready(1'b0);
    check(bnd, 8'hFF);
    arm;
    i_host.frame(1'b1, 1'b0, epb_pkg::OP_EXT, 8'h00, 16'h0000);
    wait_ready(1'b0);
    check(lck, 1'b0);
    $display("refusal test done");
  endtask : t_refused
  task automatic t_boundary;
    logic [7:0] a [3] = '{8'h44, 8'hC5, 8'h46};
    int s0;
    arm;
    cmd(1'b1, epb_pkg::OP_CLEAR, 8'hFF);
    wait_ready(1'b1);
    check(bnd, 8'hFF);
    s0 = starts;
    mw(8'hFF);
    check(8'(starts - s0), 8'h01);
    check(last_a, 8'h7F);
    check(last_d[15:8], 8'hA5);
    check(last_d[7:0], 8'hC3);
    arm;
    cmd(1'b0, epb_pkg::OP_EXT, 8'hC0);
    cmd(1'b1, epb_pkg::OP_WRITE, 8'hC5);
    wait_ready(1'b0);
    arm;
    cmd(1'b1, epb_pkg::OP_WRITE, 8'hC5);
    wait_ready(1'b1);
    check(bnd, 8'h45);
    for (int i = 0; i < 3; i++) begin
      s0 = starts;
      mw(a[i]);
      check(8'(starts - s0), {7'h00, i == 0});
    end
    $display("boundary test done");
  endtask : t_boundary
  task automatic t_lock;
    arm;
    cmd(1'b1, epb_pkg::OP_EXT, 8'h00);
    check(lck, 1'b0);
    wait_ready(1'b1);
    check(lck, 1'b1);
    arm;
    cmd(1'b1, epb_pkg::OP_CLEAR, 8'hFF);
    wait_ready(1'b0);
    arm;
    cmd(1'b1, epb_pkg::OP_WRITE, 8'h10);
    wait_ready(1'b0);
    arm;
    cmd(1'b1, epb_pkg::OP_EXT, 8'h00);
    wait_ready(1'b0);
    check(bnd, 8'h45);
    $display("lock test done");
  endtask : t_lock
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    t_enables;
    t_refused;
    t_boundary;
    t_lock;
    end_sim;
  end
  // watchdog at about five times the expected run
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule : epb_protect_tb_top
